// ### hw/gp_timer_group.v
// Functional notes
// R1: Compare output active/forced high or low.
// R2: Active output sets on match, clears later.
// R3: Direction status: 1 up, 0 down.
// R4: Directional mode follows direction pin level.
// R5: Clock internal or external, then prescaler.
// R6: External clock at most quarter CPU clock.
// R7: Cascade: timer two is low half.
// R8: Cascade runs directional only, any source.
// R9: Cascade period, under/overflow are 32-bit.
// R10: Cascade events flag timer two only; timer three's compare flag still fires on its own 16-bit match.
// R11: Directional counters saturate at period, zero; timer two wraps instead unless cascaded.
// R12: Decoder gives clock, direction; prescale one.
// R13: Decoder counts every edge of both channels.
// R14: Decoder inputs at most quarter CPU clock.
// R15: Timers two, three may use first enable.
// R16: Timers two, three may use first period.
// R17: Start counts on from preloaded value.
// R18: Selected event pulses converter start.
// R19: Suspend: run, stop now, or period end.
// R20: Four flags per timer, twelve total.
// R21: Compare flag two clocks, only when enabled.
// R22: Overflow, underflow, period flags two clocks later.
// R23: Compare enable bit per timer.
// R24: Direction status bits are read-only.
// R25: External pins synchronised and edge-detected.
`timescale 1ns/1ps
`include "gp_timer_consts.vh"
module gp_timer_group
(
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Per-timer control, index 0 is the first timer
  input  wire [2:0]  timer_enable,      // Start/stop of each counter
  input  wire [2:1]  use_first_enable,  // Follow first timer's enable
  input  wire [2:1]  use_first_period,  // Follow first timer's period
  input  wire [2:0]  compare_enable,    // Compare operation on
  input  wire [5:0]  count_mode,        // Two bits per timer
  input  wire [5:0]  clock_select,      // Two bits per timer
  input  wire [8:0]  prescale_log2,     // Three bits per timer, 1..128
  input  wire [2:0]  emu_free,          // Keep running in suspend
  input  wire [2:0]  emu_soft,          // Stop at period end in suspend
  input  wire        cascade_enable,    // Second and third form 32 bits
  // Global control
  input  wire [5:0]  output_polarity,   // Two bits per timer
  input  wire [5:0]  adc_event_select,  // Two bits per timer
  input  wire        emu_suspend,       // Emulator halt request
  // Values
  input  wire [47:0] period_value,      // 16 bits per timer
  input  wire [47:0] compare_value,     // 16 bits per timer
  input  wire [2:0]  counter_load,      // Preload strobe per timer
  input  wire [15:0] counter_load_value,
  // Pins and decoder channels
  input  wire        external_count_clock_pin,
  input  wire        direction_input_pin,
  input  wire        quadrature_a,
  input  wire        quadrature_b,
  // Outputs
  output reg  [2:0]  compare_output_pin,
  output reg  [2:0]  direction_status,  // Read-only status
  output reg  [47:0] counter_value,
  output reg  [2:0]  overflow_irq,
  output reg  [2:0]  underflow_irq,
  output reg  [2:0]  compare_match_irq,
  output reg  [2:0]  period_match_irq,
  output reg         adc_start
);
  integer i;                            // Loop index of the combinational process
  integer j;                            // Loop index of the register process
  // Synchronisers: stage one feeds stage two only
  reg [3:0]  sync1_q;                   // First stage
  reg [3:0]  sync2_q;                   // Second stage
  reg [3:0]  sync3_q;                   // Edge history
  // Per-timer state
  reg [15:0] cnt_q [0:2];               // Counters
  reg [15:0] cnt_d [0:2];
  reg [6:0]  ps_q [0:2];                // Prescale counters
  reg [6:0]  ps_d [0:2];
  reg [2:0]  dir_q, dir_d;              // Current direction
  reg [2:0]  arr_q, arr_d;              // Counter just moved or loaded
  reg [2:0]  act_q, act_d;              // Compare output active state
  reg [2:0]  cmpn_q, cmpn_d;            // Flips on every compare match
  reg [2:0]  estop_q, estop_d;          // Suspend stop at period end
  reg [11:0] ev_q;                      // Events, first delay stage
  reg [11:0] ev_d;                      // {period,compare,under,over}
  reg        adc_d;
  // Combinational helpers
  reg [2:0]  src_tick, tick, run, qsel;
  reg [6:0]  mask;
  reg [1:0]  md;
  reg [15:0] per_eff [0:2];
  reg        din;
  reg [32:0] st;
  reg [31:0] c32;
  reg [31:0] p32;
  wire       ext_rise;
  wire       qep_pulse;
  wire       qep_dir;

  // One step of a counter; returns {direction, count}
  function [32:0] step;
    input [31:0] c;
    input [31:0] p;
    input [31:0] maxv;
    input [1:0]  m;
    input        dn;
    input        ud;
    input        sat;
    begin
      step = {ud, c};
      case (m)
        `MODE_CUP:
        begin
          // Above period runs to the top and wraps
          step = {1'b1, ((c == p) || (c == maxv)) ? `CNT_ZERO : c + 32'h1};
        end
        `MODE_DIR:
        begin
          if (dn)
            step = {1'b1, (c >= p) ? (sat ? c : `CNT_ZERO) : c + 32'h1}; // R4 R11
          else
            step = {1'b0, (c == `CNT_ZERO) ? (sat ? c : p) : c - 32'h1}; // R4 R11
        end
        `MODE_CUD:
        begin
          if (ud)
            step = (c >= p) ? {1'b0, c - 32'h1} : {1'b1, c + 32'h1};
          else
            step = (c == `CNT_ZERO) ? {1'b1, c + 32'h1} : {1'b0, c - 32'h1};
        end
        default:
        begin
          step = {ud, c};
        end
      endcase
    end
  endfunction

  // Pin edges; any decoder edge is one count
  assign ext_rise  = sync2_q[0] & ~sync3_q[0];                  // R25
  assign qep_pulse = (sync2_q[2] ^ sync3_q[2]) | (sync2_q[3] ^ sync3_q[3]); // R13
  // Forward when channel A leads B
  assign qep_dir   = (sync2_q[2] ^ sync3_q[3]);

  // Clocking, prescale and counting
  always @*
  begin
    mask = 7'h00;
    md   = `MODE_STOP;
    din  = 1'b0;
    st   = 33'h0;
    c32  = 32'h0;
    p32  = 32'h0;
    ev_d = 12'h000;
    adc_d = 1'b0;
    for (i = 0; i < 3; i = i + 1)
    begin
      per_eff[i] = (i > 0 && use_first_period[i]) ? period_value[15:0] : period_value[16*i +: 16]; // R16
      qsel[i]    = (i > 0) && (clock_select[2*i +: 2] == `CLK_QEP);
      // Source choice
      case (clock_select[2*i +: 2])
        `CLK_INT: src_tick[i] = 1'b1;                             // R5
        `CLK_EXT: src_tick[i] = ext_rise;                         // R5 R25
        `CLK_QEP: src_tick[i] = qsel[i] & qep_pulse;              // R12
        default:  src_tick[i] = 1'b0;
      endcase
      mask    = (7'h01 << prescale_log2[3*i +: 3]) - 7'h01;
      // Decoder bypasses the prescaler
      tick[i] = src_tick[i] & (qsel[i] | (ps_q[i] == mask));      // R12
      // Shared start bit, and suspend stop
      run[i]  = ((i > 0 && use_first_enable[i]) ? timer_enable[0] : timer_enable[i]) // R15
              & ~(emu_suspend & ~emu_free[i] & (~emu_soft[i] | estop_q[i])); // R19
      ps_d[i] = (!run[i] || tick[i]) ? 7'h00 : (src_tick[i] ? ps_q[i] + 7'h01 : ps_q[i]);
      md      = count_mode[2*i +: 2];
      din     = qsel[i] ? qep_dir : sync2_q[1];                   // R4 R12
      st      = step({16'h0, cnt_q[i]}, {16'h0, per_eff[i]}, `CNT16_MAX, md, din, dir_q[i], i != 1);
      // Up modes report up, except second and third timers when cascaded
      dir_d[i] = (md == `MODE_DIR || md == `MODE_CUD) ? st[32] : 1'b1; // R3
      cnt_d[i] = (run[i] && tick[i] && md != `MODE_STOP) ? st[15:0] : cnt_q[i]; // R17
      arr_d[i] = (run[i] && tick[i] && md != `MODE_STOP) || counter_load[i];
      if (counter_load[i])
        cnt_d[i] = counter_load_value;                            // R17
    end
    // Cascade: one 32-bit directional counter from the second timer's clock
    if (cascade_enable)
    begin
      c32 = {cnt_q[2], cnt_q[1]};                                 // R7
      p32 = {period_value[47:32], period_value[31:16]};           // R9
      din = qsel[1] ? qep_dir : sync2_q[1];                       // R8
      st  = step(c32, p32, `CNT32_MAX, `MODE_DIR, din, dir_q[1], 1'b1); // R8 R11
      dir_d[1] = st[32];
      dir_d[2] = st[32];
      // Own modes are ignored: only the pair's tick moves either half
      arr_d[1] = (run[1] && tick[1]) || counter_load[1];
      arr_d[2] = arr_d[1] | counter_load[2];
      cnt_d[1] = cnt_q[1];
      cnt_d[2] = cnt_q[2];
      if (run[1] && tick[1])
      begin
        cnt_d[1] = st[15:0];                                      // R7
        cnt_d[2] = st[31:16];
      end
      if (counter_load[2])
        cnt_d[2] = counter_load_value;
      if (counter_load[1])
        cnt_d[1] = counter_load_value;
    end
    // Event detection on the cycle a counter shows a new value
    for (i = 0; i < 3; i = i + 1)
    begin
      ev_d[i]     = arr_q[i] && cnt_q[i] == 16'hFFFF;             // R22
      ev_d[3+i]   = arr_q[i] && cnt_q[i] == 16'h0000;             // R22
      ev_d[6+i]   = arr_q[i] && compare_enable[i]
                  && cnt_q[i] == compare_value[16*i +: 16];       // R21 R23
      ev_d[9+i]   = arr_q[i] && cnt_q[i] == per_eff[i];           // R22
    end
    if (cascade_enable)
    begin
      c32 = {cnt_q[2], cnt_q[1]};
      p32 = {period_value[47:32], period_value[31:16]};
      ev_d[1]  = arr_q[1] && c32 == `CNT32_MAX;                   // R9 R10
      ev_d[4]  = arr_q[1] && c32 == `CNT_ZERO;                    // R9 R10
      ev_d[10] = arr_q[1] && c32 == p32;                          // R9 R10
      ev_d[2]  = 1'b0;                                            // R10
      ev_d[5]  = 1'b0;                                            // R10
      ev_d[11] = 1'b0;                                            // R10
    end
    // Compare output state; second match or period ends the pulse
    for (i = 0; i < 3; i = i + 1)
    begin
      md        = cascade_enable && i > 0 ? `MODE_DIR : count_mode[2*i +: 2];
      cmpn_d[i] = ev_d[6+i] ? ~cmpn_q[i] : cmpn_q[i];
      act_d[i]  = act_q[i];
      if (md == `MODE_CUP)
      begin
        if (ev_d[6+i])
          act_d[i] = 1'b1;                                        // R2
        else if (ev_d[9+i] || (cascade_enable && i == 2 && ev_d[10]))
          act_d[i] = 1'b0;                                        // R2
      end
      else if (ev_d[6+i])
        act_d[i] = ~cmpn_q[i];                                    // R2
      estop_d[i] = emu_suspend & (estop_q[i] | ev_d[9+i] | ev_d[3+i]); // R19
      // Converter start on the chosen event
      case (adc_event_select[2*i +: 2])
        `ADC_UNDER:  adc_d = adc_d | ev_q[3+i];                   // R18
        `ADC_PERIOD: adc_d = adc_d | ev_q[9+i];                   // R18
        `ADC_CMP:    adc_d = adc_d | ev_q[6+i];                   // R18
        default:     adc_d = adc_d;
      endcase
    end
    if (cascade_enable)
      estop_d[2] = estop_d[1];
  end

  // Registers
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q            <= 4'h0;
      sync2_q            <= 4'h0;
      sync3_q            <= 4'h0;
      dir_q              <= 3'h7;
      arr_q              <= 3'h0;
      act_q              <= 3'h0;
      cmpn_q             <= 3'h0;
      estop_q            <= 3'h0;
      ev_q               <= 12'h000;
      compare_output_pin <= 3'h0;
      direction_status   <= 3'h7;
      counter_value      <= 48'h0;
      overflow_irq       <= 3'h0;
      underflow_irq      <= 3'h0;
      compare_match_irq  <= 3'h0;
      period_match_irq   <= 3'h0;
      adc_start          <= 1'b0;
      for (j = 0; j < 3; j = j + 1)
      begin
        cnt_q[j] <= 16'h0000;
        ps_q[j]  <= 7'h00;
      end
    end
    else
    begin
      // Two-stage sync then edge history
      sync1_q <= {quadrature_b, quadrature_a, direction_input_pin, external_count_clock_pin}; // R25
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      dir_q   <= dir_d;
      arr_q   <= arr_d;
      act_q   <= act_d;
      cmpn_q  <= cmpn_d;
      estop_q <= estop_d;
      ev_q    <= ev_d;
      // Second delay stage: flags land two clocks after the event
      overflow_irq      <= ev_q[2:0];                             // R20 R22
      underflow_irq     <= ev_q[5:3];                             // R20 R22
      compare_match_irq <= ev_q[8:6];                             // R20 R21
      period_match_irq  <= ev_q[11:9];                            // R20 R22
      adc_start         <= adc_d;                                 // R18
      direction_status  <= dir_q;                                 // R3 R24
      for (j = 0; j < 3; j = j + 1)
      begin
        cnt_q[j] <= cnt_d[j];
        ps_q[j]  <= ps_d[j];
        counter_value[16*j +: 16] <= cnt_d[j];
        // Forced levels need no match
        case (output_polarity[2*j +: 2])
          `POL_FLOW:  compare_output_pin[j] <= 1'b0;              // R1
          `POL_FHIGH: compare_output_pin[j] <= 1'b1;              // R1
          `POL_AHIGH: compare_output_pin[j] <= act_d[j];          // R1 R2
          default:    compare_output_pin[j] <= ~act_d[j];         // R1 R2
        endcase
      end
    end
  end
endmodule // gp_timer_group

// ### hw/gp_timer_consts.vh
`ifndef GP_TIMER_CONSTS_VH
`define GP_TIMER_CONSTS_VH
// Counting modes, two bits per timer
`define MODE_STOP   2'h0
`define MODE_CUP    2'h1
`define MODE_DIR    2'h2
`define MODE_CUD    2'h3
// Compare output polarity, two bits per timer
`define POL_FLOW    2'h0
`define POL_ALOW    2'h1
`define POL_AHIGH   2'h2
`define POL_FHIGH   2'h3
// Clock source select, two bits per timer
`define CLK_INT     2'h0
`define CLK_EXT     2'h1
`define CLK_QEP     2'h2
// Event that starts the converter, two bits per timer
`define ADC_NONE    2'h0
`define ADC_UNDER   2'h1
`define ADC_PERIOD  2'h2
`define ADC_CMP     2'h3
// Counter limits
`define CNT16_MAX   32'h0000FFFF
`define CNT32_MAX   32'hFFFFFFFF
`define CNT_ZERO    32'h00000000
`endif

// ### verification/gp_timer_group_assertions.sv
`timescale 1ns/1ps
module gp_timer_group_assertions
(
  // Clock and reset
  input wire        clock,
  input wire        rstn,
  // Controls
  input wire [2:0]  compare_enable,
  input wire [5:0]  count_mode,
  input wire        cascade_enable,
  input wire [5:0]  output_polarity,
  input wire [5:0]  adc_event_select,
  input wire [47:0] period_value,
  input wire [47:0] compare_value,
  // Observed outputs
  input wire [2:0]  compare_output_pin,
  input wire [2:0]  direction_status,
  input wire [47:0] counter_value,
  input wire [2:0]  underflow_irq,
  input wire [2:0]  overflow_irq,
  input wire [2:0]  compare_match_irq,
  input wire [2:0]  period_match_irq,
  input wire        adc_start
);
  // One clock domain, so shared clocking and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // First counter, the usual subject of the event checks
  wire [15:0] c0 = counter_value[15:0];

  a_forced_high: assert property ((output_polarity[1:0] == 2'h3) [*3] |-> compare_output_pin[0])
    else $error("forced high level not driven");
  a_up_direction: assert property ((count_mode[1:0] == 2'h1) [*3] |-> direction_status[0])
    else $error("up mode not shown as up");
  a_period_flag: assert property (c0 != $past(c0) && c0 == period_value[15:0] |-> ##2 period_match_irq[0])
    else $error("period flag missing two clocks after match");
  a_period_cause: assert property (period_match_irq[0] |-> $past(c0, 2) == $past(period_value[15:0], 2))
    else $error("period flag without a match");
  a_under_cause: assert property (underflow_irq[0] |-> $past(c0, 2) == 16'h0000)
    else $error("underflow flag without zero count");
  a_over_cause: assert property (overflow_irq[0] |-> $past(c0, 2) == 16'hFFFF)
    else $error("overflow flag without all-ones count");
  a_cmp_flag: assert property (compare_enable[0] && c0 != $past(c0) && c0 == compare_value[15:0]
    |-> ##2 compare_match_irq[0])
    else $error("compare flag missing two clocks after match");
  a_cmp_cause: assert property (compare_match_irq[0]
    |-> $past(compare_enable[0], 2) && $past(c0, 2) == $past(compare_value[15:0], 2))
    else $error("compare flag without enabled match");
  a_adc_period: assert property ((adc_event_select == 6'h02) [*3] |-> adc_start == period_match_irq[0])
    else $error("converter start not with period flag");
  a_cascade_quiet: assert property (cascade_enable [*3] |-> !(period_match_irq[2] | underflow_irq[2]
    | overflow_irq[2]))
    else $error("third timer flag raised while cascaded");
endmodule // gp_timer_group_assertions

bind gp_timer_group gp_timer_group_assertions checker_i (
  .clock(clock), .rstn(rstn), .compare_enable(compare_enable), .count_mode(count_mode),
  .cascade_enable(cascade_enable), .output_polarity(output_polarity), .adc_event_select(adc_event_select),
  .period_value(period_value), .compare_value(compare_value), .compare_output_pin(compare_output_pin),
  .direction_status(direction_status), .counter_value(counter_value), .underflow_irq(underflow_irq),
  .overflow_irq(overflow_irq), .compare_match_irq(compare_match_irq), .period_match_irq(period_match_irq),
  .adc_start(adc_start));

// ### verification/pin_source.sv
`timescale 1ns/1ps
module pin_source
(
  // CPU clock paces every pin change
  input wire clock,
  // Pins toward the timers
  output reg ext_clk = 1'h0,
  output reg qa = 1'h0,
  output reg qb = 1'h0
);
  // Pins park low between bursts; set at declaration so only the tasks drive them

  // Each level held two cycles: a quarter of the CPU rate at most
  task pulses(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge clock);
      ext_clk <= 1'h1;
      repeat (2) @(posedge clock);
      ext_clk <= 1'h0;
    end
  endtask

  // Channel A leads B, one edge every two cycles, an eighth of the rate
  task quad(input int n);
    repeat (n * 4)
    begin
      repeat (2) @(posedge clock);
      {qa, qb} <= {~qb, qa};
    end
  endtask
endmodule // pin_source

// ### verification/gp_timer_group_tb.sv
`timescale 1ns/1ps
module gp_timer_group_tb;
  // Design inputs, all driven by the bench
  reg        clock, rstn, cascade_enable, emu_suspend, direction_input_pin;
  reg [2:0]  timer_enable, compare_enable, emu_free, emu_soft, counter_load;
  reg [2:1]  use_first_enable, use_first_period;
  reg [5:0]  count_mode, clock_select, output_polarity, adc_event_select;
  reg [8:0]  prescale_log2;
  reg [47:0] period_value, compare_value;
  reg [15:0] counter_load_value;
  // Design outputs and partner pins
  wire        external_count_clock_pin, quadrature_a, quadrature_b, adc_start;
  wire [2:0]  compare_output_pin, direction_status, overflow_irq, underflow_irq;
  wire [2:0]  compare_match_irq, period_match_irq;
  wire [47:0] counter_value;
  int         mismatches, comparisons, cycles;

  pin_source pin (.clock(clock), .ext_clk(external_count_clock_pin), .qa(quadrature_a), .qb(quadrature_b));
  gp_timer_group DUT (
    .clock(clock), .rstn(rstn), .timer_enable(timer_enable), .use_first_enable(use_first_enable),
    .use_first_period(use_first_period), .compare_enable(compare_enable), .count_mode(count_mode),
    .clock_select(clock_select), .prescale_log2(prescale_log2), .emu_free(emu_free), .emu_soft(emu_soft),
    .cascade_enable(cascade_enable), .output_polarity(output_polarity), .adc_event_select(adc_event_select),
    .emu_suspend(emu_suspend), .period_value(period_value), .compare_value(compare_value),
    .counter_load(counter_load), .counter_load_value(counter_load_value),
    .external_count_clock_pin(external_count_clock_pin), .direction_input_pin(direction_input_pin),
    .quadrature_a(quadrature_a), .quadrature_b(quadrature_b), .compare_output_pin(compare_output_pin),
    .direction_status(direction_status), .counter_value(counter_value), .overflow_irq(overflow_irq),
    .underflow_irq(underflow_irq), .compare_match_irq(compare_match_irq), .period_match_irq(period_match_irq),
    .adc_start(adc_start));

  initial
  begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // Hang guard, far above the 190 or so cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      mismatches++;
      end_of_test;
    end
  end

  task drive_edge;
    @(posedge clock);
  endtask

  // Sample just after the edge, once design updates have landed
  task sample(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task check(input logic [47:0] got, input logic [47:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task load(input logic [2:0] which, input logic [15:0] v);
    drive_edge;
    counter_load_value <= v;
    counter_load <= which;
    drive_edge;
    counter_load <= 3'h0;
  endtask

  task t_forced;
    drive_edge;
    output_polarity <= 6'h3F;
    sample(3);
    check(compare_output_pin, 3'h7, "forced high");
    drive_edge;
    output_polarity <= 6'h00;
    sample(3);
    check(compare_output_pin, 3'h0, "forced low");
    $display("test forced done");
  endtask

  // Up mode, period 3, compare 2: flag and converter start two clocks late
  task t_up;
    int n;
    int hi;
    int cm;
    int uf;
    n = 0;
    hi = 0;
    cm = 0;
    uf = 0;
    drive_edge;
    period_value[15:0] <= 16'h0003;
    compare_value[15:0] <= 16'h0002;
    compare_enable[0] <= 1'h1;
    adc_event_select <= 6'h02;
    output_polarity[1:0] <= 2'h2;
    count_mode[1:0] <= 2'h1;
    timer_enable[0] <= 1'h1;
    while (counter_value[15:0] !== 16'h0003 && n < 50)
    begin
      sample(1);
      n++;
    end
    sample(2);
    check(period_match_irq[0], 1'h1, "period flag");
    check(adc_start, 1'h1, "converter start");
    check(direction_status[0], 1'h1, "up status");
    // High from compare match to period match: one cycle of four
    for (int i = 0; i < 8; i++)
    begin
      sample(1);
      hi += compare_output_pin[0];
      cm += compare_match_irq[0];
      uf += underflow_irq[0];
    end
    check(hi, 2, "active cycles");
    check(cm, 2, "compare flags");
    check(uf, 2, "underflow flags");
    // Active low: the pin is low for the same cycles
    output_polarity[1:0] <= 2'h1;
    sample(1);
    hi = 0;
    for (int i = 0; i < 8; i++)
    begin
      sample(1);
      hi += !compare_output_pin[0];
    end
    check(hi, 2, "active low cycles");
    // Overflow flag two clocks after the counter shows all ones
    load(3'h1, 16'hFFFE);
    sample(3);
    check(overflow_irq[0], 1'h1, "overflow flag");
    timer_enable[0] <= 1'h0;
    $display("test up done");
  endtask

  task t_dir;
    period_value[47:32] <= 16'h0005;
    count_mode[5:4] <= 2'h2;
    direction_input_pin <= 1'h0;
    load(3'h4, 16'h0002);
    timer_enable[2] <= 1'h1;
    sample(12);
    check(counter_value[47:32], 16'h0000, "held at zero");
    check(direction_status[2], 1'h0, "down status");
    drive_edge;
    direction_input_pin <= 1'h1;
    sample(16);
    check(counter_value[47:32], 16'h0005, "held at period");
    check(direction_status[2], 1'h1, "up status");
    timer_enable[2] <= 1'h0;
    $display("test directional done");
  endtask

  // Third timer follows first enable and period from a preloaded offset
  task t_sync;
    count_mode <= 6'h11;
    use_first_enable <= 2'h2;
    use_first_period <= 2'h2;
    period_value[47:32] <= 16'h0001;
    period_value[15:0] <= 16'h0007;
    load(3'h1, 16'h0000);
    load(3'h4, 16'h0002);
    timer_enable[0] <= 1'h1;
    sample(6);
    check(counter_value[15:0], 16'h0006, "first count");
    check(counter_value[47:32], 16'h0000, "offset on shared period");
    timer_enable[0] <= 1'h0;
    use_first_enable <= 2'h0;
    use_first_period <= 2'h0;
    $display("test sync done");
  endtask

  task t_suspend;
    logic [15:0] v;
    emu_free[0] <= 1'h0;
    emu_suspend <= 1'h1;
    timer_enable[0] <= 1'h1;
    sample(3);
    v = counter_value[15:0];
    sample(5);
    check(counter_value[15:0], v, "frozen");
    emu_suspend <= 1'h0;
    sample(3);
    check(counter_value[15:0] != v, 1'h1, "resumed");
    // Soft stop: runs on to the end of the period, then holds at zero
    emu_soft[0] <= 1'h1;
    emu_suspend <= 1'h1;
    sample(12);
    check(counter_value[15:0], 16'h0000, "soft stop");
    emu_suspend <= 1'h0;
    emu_soft[0] <= 1'h0;
    timer_enable[0] <= 1'h0;
    emu_free[0] <= 1'h1;
    $display("test suspend done");
  endtask

  // Pair runs up from just below the roll-over and stops at 32-bit period
  task t_cascade;
    cascade_enable <= 1'h1;
    count_mode[3:2] <= 2'h2;
    period_value[47:16] <= 32'h00010003;
    load(3'h2, 16'hFFFE);
    load(3'h4, 16'h0000);
    timer_enable[1] <= 1'h1;
    sample(30);
    check(counter_value[47:16], 32'h00010003, "cascade period");
    timer_enable[1] <= 1'h0;
    cascade_enable <= 1'h0;
    $display("test cascade done");
  endtask

  // Five pin pulses give five counts; two decoder cycles give eight
  task t_sources;
    period_value <= 48'h0000_0100_FFFF;
    clock_select <= 6'h09;
    prescale_log2[5:3] <= 3'h3;
    direction_input_pin <= 1'h0;
    load(3'h3, 16'h0000);
    timer_enable[1:0] <= 2'h3;
    pin.pulses(5);
    pin.quad(2);
    sample(8);
    check(counter_value[15:0], 16'h0005, "pin count");
    check(counter_value[31:16], 16'h0008, "decoder count");
    timer_enable <= 3'h0;
    $display("test sources done");
  endtask

  task end_of_test;
    $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {rstn, cascade_enable, emu_suspend, counter_load, counter_load_value} = '0;
    {timer_enable, compare_enable, emu_soft, use_first_enable, use_first_period} = '0;
    {count_mode, clock_select, output_polarity, adc_event_select, prescale_log2} = '0;
    {period_value, compare_value} = '0;
    emu_free = 3'h7;
    direction_input_pin = 1'h1;
    repeat (8) @(posedge clock);
    rstn <= 1'h1;
    t_forced;
    t_up;
    t_dir;
    t_sync;
    t_suspend;
    t_cascade;
    t_sources;
    end_of_test;
  end
endmodule // gp_timer_group_tb
